/* core/gcmux_network.sv */
/*
 global clock network: source routing, eight glitch-free muxes with
 plain, mux and gated modes, side spines and centre spine.
 assumes select and routing inputs are static or meet the setup window
 before the chosen clock's rising edge; i_ref_clk only clocks reset.
 a change of a mux's mode restarts its switch from reset for one
 reference cycle, so the output may be cut short at that moment.
 a source that stops while chosen holds its mux output at its last level
 until the mode changes; no other select can complete meanwhile.
 the select of a mux may toggle again only once the last change has
 finished in both clock domains; faster toggling may stall the switch.
 in plain buffer and off modes the select input is ignored.
 in gated mode the gate enable takes the place of the select.
 diff pair bits are read at even mux indices only.
 manager feeds default to the first even or odd mux of each side.
*/
`default_nettype none
`include "gcmux_consts.svh"

module gcmux_switch
#(
	parameter int SYNC = `GCMUX_SYNC_STAGES
)
(
	input  wire logic i_clk_zero,
	input  wire logic i_clk_one,
	input  wire logic i_sel,
	input  wire logic i_reset_n,
	output logic      o_clk
);
	logic [SYNC-1:0] sync_zero_r;
	logic [SYNC-1:0] sync_one_r;
	logic            en_zero_r;
	logic            en_one_r;
	logic            want_zero;
	logic            want_one;

	// handshake - each side waits for the other's enable to drop
	assign want_zero = ~i_sel & ~en_one_r;
	assign want_one  =  i_sel & ~en_zero_r;

	// per-domain sync - each request is synchronised on its own clock
	always_ff @(posedge i_clk_zero or negedge i_reset_n)
	begin
		if (!i_reset_n)
			sync_zero_r <= '0;
		else
			sync_zero_r <= {sync_zero_r[SYNC-2:0], want_zero};
	end

	always_ff @(posedge i_clk_one or negedge i_reset_n)
	begin
		if (!i_reset_n)
			sync_one_r <= '0;
		else
			sync_one_r <= {sync_one_r[SYNC-2:0], want_one};
	end

	// falling-edge enables - change only while the clock is low
	always_ff @(negedge i_clk_zero or negedge i_reset_n)
	begin
		if (!i_reset_n)
			en_zero_r <= 1'b0;
		else
			en_zero_r <= sync_zero_r[SYNC-1] & ~en_one_r;
	end

	always_ff @(negedge i_clk_one or negedge i_reset_n)
	begin
		if (!i_reset_n)
			en_one_r <= 1'b0;
		else
			en_one_r <= sync_one_r[SYNC-1] & ~en_zero_r;
	end

	// output select - whole phases of one clock at a time
	assign o_clk = (i_clk_zero & en_zero_r) | (i_clk_one & en_one_r);

	// one enable - never both sources at once
	chk_enables_exclusive: assert property (
		@(posedge i_clk_zero) disable iff (!i_reset_n)
		!(en_zero_r && en_one_r))
		else $error("both mux enables high");

	sequence s_sel_one_held;
		i_sel [*8];
	endsequence

	// select one - zero side shuts off once one is held
	chk_sel_one_off: assert property (
		@(posedge i_clk_zero) disable iff (!i_reset_n)
		s_sel_one_held |-> !en_zero_r)
		else $error("zero clock still enabled with select high");

	sequence s_sel_zero_held;
		!i_sel [*8];
	endsequence

	// select zero - one side shuts off once zero is held
	chk_sel_zero_off: assert property (
		@(posedge i_clk_one) disable iff (!i_reset_n)
		s_sel_zero_held |-> !en_one_r)
		else $error("one clock still enabled with select low");

	// break first - one enable rises only with zero off
	chk_one_after_zero: assert property (
		@(negedge i_clk_one) disable iff (!i_reset_n)
		$rose(en_one_r) |-> !en_zero_r)
		else $error("one enable rose while zero enable high");

	// break first - zero enable rises only with one off
	chk_zero_after_one: assert property (
		@(negedge i_clk_zero) disable iff (!i_reset_n)
		$rose(en_zero_r) |-> !en_one_r)
		else $error("zero enable rose while one enable high");

	// quiet reset - no output pulse while held in reset
	chk_reset_quiet: assert property (
		@(posedge i_clk_one)
		!i_reset_n |-> !o_clk)
		else $error("mux output high during reset");

	// clean rise - clock one rises with the zero side shut
	chk_one_rise_clean: assert property (
		@(posedge i_clk_one) disable iff (!i_reset_n)
		en_one_r |-> !o_clk)
		else $error("output high as clock one rises");

	// clean rise - clock zero rises with the one side shut
	chk_zero_rise_clean: assert property (
		@(posedge i_clk_zero) disable iff (!i_reset_n)
		en_zero_r |-> !o_clk)
		else $error("output high as clock zero rises");
endmodule // gcmux_switch

module gcmux_network
#(
	parameter int NUM_MUX  = `GCMUX_NUM_MUX,
	parameter int PER_SIDE = `GCMUX_PER_SIDE
)
(
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_reset_n,
	input  wire logic [`GCMUX_NUM_PINS-1:0] i_global_clock_pins,
	input  wire logic [2*`GCMUX_NUM_LINES-1:0] i_route_lines,
	input  wire logic [4*`GCMUX_MGR_OUTS-1:0]  i_clock_manager_outs,
	input  wire logic [NUM_MUX-1:0]      i_sel,
	input  wire logic [NUM_MUX-1:0]      i_gate_en,
	input  wire logic [2*NUM_MUX-1:0]    i_mode,
	input  wire logic [NUM_MUX-1:0]      i_diff_pair,
	input  wire logic [NUM_MUX*`GCMUX_SRC_W-1:0] i_src_zero,
	input  wire logic [NUM_MUX*`GCMUX_SRC_W-1:0] i_src_one,
	input  wire logic [NUM_MUX-1:0]      i_to_mgr_sel,
	output logic [PER_SIDE-1:0]          o_spine_bottom,
	output logic [PER_SIDE-1:0]          o_spine_top,
	output logic [NUM_MUX-1:0]           o_centre_spine,
	output logic [3:0]                   o_clock_manager_in
);
	logic [NUM_MUX-1:0] mux_clk;
	logic               rst_meta_r;
	logic               rst_sync_r;

	// internal reset released in step with the reference clock
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_MUX; g++)
		begin : g_mux
			localparam int SIDE = g / PER_SIDE;
			localparam int PAIR = (g / 2) * 2;
			gcmux_pkg::gcmux_src_t src_a;
			gcmux_pkg::gcmux_src_t src_b;
			gcmux_pkg::gcmux_mode_e mode;
			logic [`GCMUX_NUM_SRC-1:0] pool;
			logic [`GCMUX_PER_SIDE-1:0] pins;
			logic clk_a;
			logic clk_b;
			logic sel_eff;
			logic sw_zero;
			logic sw_one;
			logic [1:0] mode_seen_r;
			logic sw_rst_n_r;

			assign src_a = i_src_zero[g*`GCMUX_SRC_W +: `GCMUX_SRC_W];
			assign src_b = i_src_one[g*`GCMUX_SRC_W +: `GCMUX_SRC_W];
			assign mode  = gcmux_pkg::gcmux_mode_e'(i_mode[2*g +: 2]);

			// side pins - a differential pair feeds only the even mux
			always_comb
			begin
				pins = i_global_clock_pins[SIDE*PER_SIDE +: PER_SIDE];
				if (i_diff_pair[PAIR] && (g % 2 == 1))
					pins[PAIR%PER_SIDE +: 2] = 2'b00;
			end

			// source pool - pins, routing lines, both side managers
			assign pool = {
				i_clock_manager_outs[(2*SIDE+1)*`GCMUX_MGR_OUTS +:
					`GCMUX_MGR_OUTS],
				i_clock_manager_outs[2*SIDE*`GCMUX_MGR_OUTS +:
					`GCMUX_MGR_OUTS],
				i_route_lines[SIDE*`GCMUX_NUM_LINES +: `GCMUX_NUM_LINES],
				pins};
			assign clk_a = pool[src_a];
			assign clk_b = pool[src_b];

			// mode - plain buffer pins select, gated uses enable
			always_comb
			begin
				unique case (mode)
					gcmux_pkg::GCMUX_MODE_MUX:   sel_eff = i_sel[g];
					gcmux_pkg::GCMUX_MODE_BUF:   sel_eff = 1'b1;
					gcmux_pkg::GCMUX_MODE_GATED: sel_eff = i_gate_en[g];
					default:                     sel_eff = 1'b0;
				endcase
			end

			// gated mode - clock zero is a constant low source
			assign sw_zero = (mode == gcmux_pkg::GCMUX_MODE_MUX) ?
				clk_a : 1'b0;
			assign sw_one  = (mode == gcmux_pkg::GCMUX_MODE_MUX) ?
				clk_b : clk_a;

			// mode change - restart the switch cleanly
			always_ff @(posedge i_ref_clk or negedge i_reset_n)
			begin
				if (!i_reset_n)
				begin
					mode_seen_r <= 2'b00;
					sw_rst_n_r  <= 1'b0;
				end
				else
				begin
					mode_seen_r <= i_mode[2*g +: 2];
					sw_rst_n_r  <= rst_sync_r &&
						(mode_seen_r == i_mode[2*g +: 2]);
				end
			end

			gcmux_switch u_switch
			(
				.i_clk_zero (sw_zero),
				.i_clk_one  (sw_one),
				.i_sel      (sel_eff),
				.i_reset_n  (sw_rst_n_r),
				.o_clk      (mux_clk[g])
			);

			sequence s_mode_off_held;
				(i_mode[2*g +: 2] == 2'b11) [*4];
			endsequence

			// off mode - a restarted switch holds its output low
			chk_off_mode_low: assert property (
				@(posedge i_ref_clk) disable iff (!rst_sync_r)
				s_mode_off_held |-> !mux_clk[g])
				else $error("mux output toggles in off mode");

			// mode change - a new mode restarts the switch
			chk_mode_restart: assert property (
				@(posedge i_ref_clk) disable iff (!rst_sync_r)
				(i_mode[2*g +: 2] != $past(i_mode[2*g +: 2])) |=>
					!sw_rst_n_r)
				else $error("mode change did not restart the switch");
		end
	endgenerate

	// differential pair - the odd mux loses both pair pins
	chk_diff_pair_quiet: assert property (
		@(posedge i_ref_clk) disable iff (!rst_sync_r)
		i_diff_pair[6] |-> (g_mux[7].pins[3:2] == 2'b00))
		else $error("odd mux still sees a differential pair pin");

	// spines - four lines per side, eight across the centre
	assign o_spine_bottom = mux_clk[PER_SIDE-1:0];
	assign o_spine_top    = mux_clk[NUM_MUX-1:PER_SIDE];
	assign o_centre_spine = {o_spine_top, o_spine_bottom};

	// manager feed - each side manager takes one same-side mux
	genvar m;
	generate
		for (m = 0; m < 4; m++)
		begin : g_mgr
			localparam int MSIDE = m / 2;
			logic [PER_SIDE-1:0] side_clk;
			logic [1:0]          pick;
			assign side_clk = mux_clk[MSIDE*PER_SIDE +: PER_SIDE];
			always_comb
			begin
				pick = 2'(m % 2);
				for (int k = PER_SIDE - 1; k >= 0; k--)
					if (i_to_mgr_sel[MSIDE*PER_SIDE + k] &&
						((k % 2) == (m % 2)))
						pick = 2'(k);
			end
			assign o_clock_manager_in[m] = side_clk[pick];
		end
	endgenerate
endmodule // gcmux_network
`default_nettype wire

/* include/gcmux_consts.svh */
/*
 constants for the global clock network: counts of pins, muxes, spines
 and source choices. assumes it is included by its bare name.
*/
// Overview of operation
// - each mux passes clock zero when select is low and clock one when high.
// - changing the chosen source never makes a glitch on the output clock.
// - while switching, output phases are never shorter than the faster input's.
// - the two clock inputs may be fully asynchronous to each other.
// - eight global pins and eight muxes, four of each on bottom and top.
// - each mux input picks a side pin, a routing line or a manager output.
// - adjacent muxes share a pin pair; a differential clock feeds one mux.
// - a plain global buffer drives one clock with no selection.
// - a gated buffer uses the switch mechanism to gate one clock cleanly.
// - each mux output goes to its side spine and to the side manager of the same even or odd index.
// - each side spine has four lines; they join an eight-line centre spine.
`ifndef GCMUX_CONSTS_SVH
`define GCMUX_CONSTS_SVH
`define GCMUX_NUM_PINS      8
`define GCMUX_NUM_MUX       8
`define GCMUX_PER_SIDE      4
`define GCMUX_NUM_LINES     4
`define GCMUX_MGR_OUTS      4
`define GCMUX_NUM_SRC       16
`define GCMUX_SRC_W         4
`define GCMUX_SRC_PIN_BASE  4'h0
`define GCMUX_SRC_LINE_BASE 4'h4
`define GCMUX_SRC_MGRL_BASE 4'h8
`define GCMUX_SRC_MGRR_BASE 4'hC
`define GCMUX_SYNC_STAGES   2
`endif

/* include/gcmux_pkg.sv */
/*
 types for the global clock network.
 assumes gcmux_consts.svh is on the include path.
*/
`default_nettype none
`include "gcmux_consts.svh"
package gcmux_pkg;
	typedef logic [`GCMUX_SRC_W-1:0] gcmux_src_t;
	typedef enum logic [1:0]
	{
		GCMUX_MODE_MUX   = 2'b00,
		GCMUX_MODE_BUF   = 2'b01,
		GCMUX_MODE_GATED = 2'b10
	} gcmux_mode_e;
endpackage
`default_nettype wire

/* verif/gcmux_clk_src.sv */
/*
 clock sources: 8 pins, 8 routing lines, 16 manager outputs.
 assumes nothing of the block; each source free runs at its own rate.
*/
`default_nettype none
module gcmux_clk_src
(
	output logic [7:0]  o_pins,
	output logic [7:0]  o_lines,
	output logic [15:0] o_mgr
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] clk_r;
	// unrelated rates, edges off whole ns
	for (genvar g = 0; g < 32; g++)
	begin : g_src
		initial
		begin
			clk_r[g] = 1'b0;
			#0.5;
			forever #(5 + g) clk_r[g] = ~clk_r[g];
		end
	end
	// raw sources, the tap ahead of each mux
	assign o_pins  = clk_r[7:0];
	assign o_lines = clk_r[15:8];
	assign o_mgr   = clk_r[31:16];
endmodule // gcmux_clk_src
`default_nettype wire

/* verif/tb_glitchless_global_clock_mux.sv */
/*
 bench for the clock network: periods, switching, buffer and gating.
 assumes gcmux_clk_src drives all clock sources.
*/
`default_nettype none
module tb_glitchless_global_clock_mux;
	timeunit 1ns;
	timeprecision 100ps;
	logic        i_ref_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic [7:0]  sel = 8'h00;
	logic [7:0]  gate = 8'h00;
	logic [7:0]  to_mgr = 8'h00;
	logic [7:0]  diff = 8'h00;
	logic [15:0] mode = 16'h0000;
	logic [31:0] sz = 32'h0002_0000;
	logic [31:0] so = 32'h1111_1111;
	wire  [31:0] srcs;
	wire  [19:0] obs;
	int          error_cnt = 0;
	int          n_tests = 0;
	realtime     lc = 0;
	realtime     mn = 1000;
	always #4 i_ref_clk = ~i_ref_clk;
	gcmux_clk_src i_src (.o_pins(srcs[7:0]), .o_lines(srcs[15:8]),
		.o_mgr(srcs[31:16]));
	gcmux_network i_dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
		.i_global_clock_pins(srcs[7:0]), .i_route_lines(srcs[15:8]),
		.i_clock_manager_outs(srcs[31:16]), .i_sel(sel),
		.i_gate_en(gate), .i_mode(mode), .i_diff_pair(diff),
		.i_src_zero(sz), .i_src_one(so), .i_to_mgr_sel(to_mgr),
		.o_spine_bottom(obs[3:0]), .o_spine_top(obs[7:4]),
		.o_centre_spine(obs[15:8]), .o_clock_manager_in(obs[19:16]));
	always @(obs[0])
	begin
		if ($realtime - lc < mn)
			mn = $realtime - lc;
		lc = $realtime;
	end
	task automatic cmp_i(string n, int e, int g);
		n_tests++;
		if (e !== g)
		begin
			error_cnt++;
			$display("CHECK FAILED %s exp %0d got %0d", n, e, g);
		end
	endtask
	task automatic cmp_b(string n, logic e, logic g);
		n_tests++;
		if (e !== g)
		begin
			error_cnt++;
			$display("CHECK FAILED %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic per(int k, int e);
		realtime t;
		repeat (8) @(posedge obs[k]);
		t = $realtime;
		@(posedge obs[k]);
		cmp_i("period", e, int'($realtime - t));
	endtask
	task automatic t_select;
		per(0, 10);
		per(4, 22);
		@(posedge i_ref_clk);
		sel[0] <= 1'b1;
		per(0, 12);
	endtask
	task automatic t_sources;
		@(posedge i_ref_clk);
		sz[7:4] <= 4'h4;
		per(1, 26);
		@(posedge i_ref_clk);
		sz[7:4] <= 4'h8;
		per(1, 42);
		@(posedge i_ref_clk);
		sz[7:4] <= 4'hC;
		per(1, 50);
	endtask
	task automatic t_switch;
		mn = 1000;
		repeat (6)
		begin
			repeat (12) @(posedge i_ref_clk);
			sel[0] <= ~sel[0];
		end
		per(0, 12);
		cmp_b("min phase", 1'b1, mn >= 5);
		cmp_b("no glitch", 1'b1, mn >= 5);
	endtask
	task automatic t_spine;
		per(8, 12);
		per(12, 22);
		per(16, 12);
		per(18, 22);
		@(posedge i_ref_clk);
		to_mgr[3] <= 1'b1;
		per(17, 10);
	endtask
	task automatic t_buf;
		@(posedge i_ref_clk);
		mode[5:4] <= 2'b01;
		sel[2] <= 1'b1;
		sz[11:8] <= 4'h3;
		so[11:8] <= 4'h0;
		per(2, 16);
	endtask
	task automatic t_gate;
		@(posedge i_ref_clk);
		mode[7:6] <= 2'b10;
		repeat (30) @(posedge i_ref_clk);
		repeat (10) @(posedge i_ref_clk)
			cmp_b("gated off", 1'b0, obs[3]);
		gate[3] <= 1'b1;
		per(3, 10);
		@(posedge i_ref_clk);
		gate[3] <= 1'b0;
		repeat (30) @(posedge i_ref_clk);
		cmp_b("gated off again", 1'b0, obs[3]);
		mode[7:6] <= 2'b11;
		repeat (30) @(posedge i_ref_clk);
		cmp_b("mux off", 1'b0, obs[3]);
	endtask
	task automatic t_diff;
		@(posedge i_ref_clk);
		sz[31:24] <= 8'h22;
		per(6, 22);
		per(7, 22);
		@(posedge i_ref_clk);
		diff[6] <= 1'b1;
		per(6, 22);
		repeat (20) @(posedge i_ref_clk);
		cmp_b("diff odd off", 1'b0, obs[7]);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		error_cnt++;
		finish_test();
	end
	initial
	begin
		repeat (9) @(posedge i_ref_clk);
		cmp_b("reset low", 1'b0, |obs);
		@(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		// select moves on whole ns, sources on half ns
		t_select();
		t_sources();
		t_switch();
		t_spine();
		t_buf();
		t_gate();
		t_diff();
		finish_test();
	end
endmodule // tb_glitchless_global_clock_mux
`default_nettype wire
